// *** core/pivm_pkg.sv ***
package pivm_pkg;

    // Number of user interrupt inputs of the core's nested_vector_irq_ctrl and the width of a position.
    localparam int NUM_USER = 32;
    localparam int POS_W = 5;

    // Vector table layout: core exceptions first, then one word per user position.
    localparam logic [31:0] CORE_VEC_FIRST = 32'h0000_0000;
    localparam logic [31:0] USER_VEC_FIRST = 32'h0000_0040;

    // Fixed user positions of each peripheral request.
    localparam logic [4:0] POS_GPIO = 5'h00;
    localparam logic [4:0] POS_FLASH = 5'h01;
    localparam logic [4:0] POS_UART = 5'h04;
    localparam logic [4:0] POS_SPI = 5'h05;
    localparam logic [4:0] POS_RADIO = 5'h06;
    localparam logic [4:0] POS_WATCHDOG = 5'h07;
    localparam logic [4:0] POS_ADC = 5'h0D;
    localparam logic [4:0] POS_I2C_TWO = 5'h0E;
    localparam logic [4:0] POS_I2C_ONE = 5'h0F;
    localparam logic [4:0] POS_MULTIFUNCTION_TIMER_ONE_A = 5'h11;
    localparam logic [4:0] POS_MULTIFUNCTION_TIMER_ONE_B = 5'h12;
    localparam logic [4:0] POS_MULTIFUNCTION_TIMER_TWO_A = 5'h13;
    localparam logic [4:0] POS_MULTIFUNCTION_TIMER_TWO_B = 5'h14;
    localparam logic [4:0] POS_RTC = 5'h15;
    localparam logic [4:0] POS_DMA = 5'h17;

    // Positions with a source attached, and positions classed as critical.
    localparam logic [31:0] CONNECTED_MASK = 32'h00BE_E0F3;
    localparam logic [31:0] CRITICAL_MASK = 32'h0000_0040;

    // Priority level that every user position holds after reset.
    localparam int PRIO_RESET_LEVEL = 0;

    // Core exception numbers served by the lookup port.
    localparam logic [3:0] EXC_NUM_RESET = 4'h1;
    localparam logic [3:0] EXC_NUM_NMI = 4'h2;
    localparam logic [3:0] EXC_NUM_SEVERE_FAULT = 4'h3;
    localparam logic [3:0] EXC_NUM_SUPERVISOR_CALL = 4'hB;
    localparam logic [3:0] EXC_NUM_PENDING_SERVICE = 4'hE;
    localparam logic [3:0] EXC_NUM_PERIODIC_TICK = 4'hF;

    // Core exception priorities; the first three are fixed, the rest settable.
    localparam logic signed [3:0] PRIO_RESET_EXC = -4'sh3;
    localparam logic signed [3:0] PRIO_NMI_EXC = -4'sh2;
    localparam logic signed [3:0] PRIO_SEVERE_FAULT_EXC = -4'sh1;
    localparam logic signed [3:0] PRIO_SUPERVISOR_CALL_EXC = 4'sh3;
    localparam logic signed [3:0] PRIO_PENDING_SERVICE_EXC = 4'sh5;
    localparam logic signed [3:0] PRIO_PERIODIC_TICK_EXC = 4'sh6;

    // Sweep states, Gray coded along idle, run, publish.
    typedef enum logic [1:0]
    {
        PIVM_SCAN_IDLE = 2'b00,
        PIVM_SCAN_RUN = 2'b01,
        PIVM_SCAN_PUBLISH = 2'b11
    } pivm_scan_type;

endpackage

// *** core/pivm_prio_table.sv ***
`timescale 1ns/1ps

module pivm_prio_table #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 2,
    parameter int AW = 5
)
(
    // Clock and synchronous reset.
    input wire logic clk,
    input wire logic nrst,
    // Write port.
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port, data registered.
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    import pivm_pkg::*;

    logic [WIDTH-1:0] mem_r [DEPTH];

    // Refuse a table that the address cannot cover.
    initial
    begin
        if (DEPTH < 1 || DEPTH > (1 << AW) || WIDTH < 1)
            $error("pivm_prio_table: unsupported geometry");
    end

    // Entries clear to the reset level and take writes afterwards.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= WIDTH'(PRIO_RESET_LEVEL);
        end
        else if (wr_en && int'(wr_addr) < DEPTH)
            mem_r[wr_addr] <= wr_data;
    end

    // Read data comes from a register; a same-cycle write shows on the next read.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            rd_data <= WIDTH'(PRIO_RESET_LEVEL);
        else if (int'(rd_addr) < DEPTH)
            rd_data <= mem_r[rd_addr];
        else
            rd_data <= '0;
    end

endmodule // pivm_prio_table

// *** core/pivm_irq_vector_map.sv ***
// What this block does
// R1: Present 32 user interrupt inputs, vectors 0x40 to 0xBC above core vectors 0x00-0x3C.
// R2: Each peripheral request drives one fixed user input.
// R3: GPIO request drives position 0, vector 0x40.
// R4: Flash controller request drives position 1, vector 0x44.
// R5: Serial port request drives position 4, vector 0x50.
// R6: SPI request drives position 5, vector 0x54.
// R7: Radio controller request drives position 6, vector 0x58, classed critical.
// R8: Watchdog request drives position 7, vector 0x5C.
// R9: ADC request drives position 13, vector 0x74.
// R10: Second I2C request drives position 14, vector 0x78.
// R11: First I2C request drives position 15, vector 0x7C.
// R12: Timer one channels A and B drive positions 17 and 18, vectors 0x84, 0x88.
// R13: Timer two channels A and B drive positions 19 and 20, vectors 0x8C, 0x90.
// R14: Real-time clock request drives position 21, vector 0x94.
// R15: Positions 2, 3, 8-12, 16 and 22 have no source and stay low.
// R16: Every position starts at priority level 0 and stays programmable.
// R17: Reset, NMI and severe fault carry fixed priorities -3, -2, -1; reset vector 0x04.
// R18: Supervisor call, pending service, tick are settable, listed 3, 5, 6, vectors 0x2C/0x38/0x3C.
// R19: DMA request drives position 23, vector 0x9C; positions 24-31 stay low.
// R20: Requests are levels held until cleared, synchronous, cleared by core reset.
`timescale 1ns/1ps

module pivm_irq_vector_map #(
    parameter int PRIO_BITS = 2
)
(
    // Clock and synchronous active-low core reset.
    input wire logic clk,
    input wire logic nrst,

    // Peripheral interrupt requests, levels on clk.
    input wire logic gpio_irq,
    input wire logic flash_irq,
    input wire logic uart_irq,
    input wire logic spi_irq,
    input wire logic radio_irq,
    input wire logic watchdog_irq,
    input wire logic adc_irq,
    input wire logic i2c_two_irq,
    input wire logic i2c_one_irq,
    input wire logic multifunction_timer_one_a_irq,
    input wire logic multifunction_timer_one_b_irq,
    input wire logic multifunction_timer_two_a_irq,
    input wire logic multifunction_timer_two_b_irq,
    input wire logic rtc_irq,
    input wire logic dma_irq,

    // Priority programming from the core.
    input wire logic prio_wr_en,
    input wire logic [pivm_pkg::POS_W-1:0] prio_wr_pos,
    input wire logic [PRIO_BITS-1:0] prio_wr_level,

    // Core exception lookup.
    input wire logic [3:0] sys_exc_num,

    // User interrupt lines towards the nested_vector_irq_ctrl.
    output logic [pivm_pkg::NUM_USER-1:0] user_irq,
    output logic [pivm_pkg::NUM_USER-1:0] user_irq_rise,

    // Most urgent pending user interrupt.
    output logic pend_valid,
    output logic [pivm_pkg::POS_W-1:0] pend_pos,
    output logic [31:0] pend_vector_addr,
    output logic [PRIO_BITS-1:0] pend_level,
    output logic pend_critical,

    // Core exception answer.
    output logic sys_exc_valid,
    output logic [31:0] sys_exc_addr,
    output logic signed [3:0] sys_exc_prio,
    output logic sys_exc_fixed
);
    import pivm_pkg::*;

    // Refuse priority widths the level encoding cannot carry.
    initial
    begin
        if (PRIO_BITS < 1 || PRIO_BITS > 8)
            $error("pivm_irq_vector_map: PRIO_BITS must be 1 to 8");
    end

    // Source vector assembled by position.
    logic [NUM_USER-1:0] src_vec;
    // Source vector after the connection mask.
    logic [NUM_USER-1:0] masked_src;
    // Registered user lines and their previous value.
    logic [NUM_USER-1:0] user_irq_r;
    logic [NUM_USER-1:0] user_irq_prev_r;

    // Sweep state and pointers.
    pivm_scan_type scan_st_r;
    pivm_scan_type scan_st_nxt;
    logic [POS_W-1:0] scan_addr_r;
    logic [POS_W-1:0] data_pos_r;
    logic data_vld_r;

    // Priority read data for data_pos_r.
    logic [PRIO_BITS-1:0] rd_level;

    // Best candidate collected during the sweep.
    logic best_vld_r;
    logic [POS_W-1:0] best_pos_r;
    logic [PRIO_BITS-1:0] best_level_r;
    logic best_crit_r;

    // Candidate after considering the entry that arrives this cycle.
    logic take;
    logic cand_vld;
    logic [POS_W-1:0] cand_pos;
    logic [PRIO_BITS-1:0] cand_level;
    logic cand_crit;
    logic entry_crit;

    // Published result registers.
    logic pend_valid_r;
    logic [POS_W-1:0] pend_pos_r;
    logic [31:0] pend_vector_addr_r;
    logic [PRIO_BITS-1:0] pend_level_r;
    logic pend_critical_r;

    // Exception lookup registers.
    logic sys_exc_valid_r;
    logic [31:0] sys_exc_addr_r;
    logic signed [3:0] sys_exc_prio_r;
    logic sys_exc_fixed_r;

    // Place each peripheral request on its fixed position; the rest stay low.
    always_comb
    begin
        src_vec = '0;                                           // [R15] [R19]
        src_vec[POS_GPIO] = gpio_irq;                           // [R3]
        src_vec[POS_FLASH] = flash_irq;                         // [R4]
        src_vec[POS_UART] = uart_irq;                           // [R5]
        src_vec[POS_SPI] = spi_irq;                             // [R6]
        src_vec[POS_RADIO] = radio_irq;                         // [R7]
        src_vec[POS_WATCHDOG] = watchdog_irq;                   // [R8]
        src_vec[POS_ADC] = adc_irq;                             // [R9]
        src_vec[POS_I2C_TWO] = i2c_two_irq;                     // [R10]
        src_vec[POS_I2C_ONE] = i2c_one_irq;                     // [R11]
        src_vec[POS_MULTIFUNCTION_TIMER_ONE_A] = multifunction_timer_one_a_irq; // [R12]
        src_vec[POS_MULTIFUNCTION_TIMER_ONE_B] = multifunction_timer_one_b_irq; // [R12]
        src_vec[POS_MULTIFUNCTION_TIMER_TWO_A] = multifunction_timer_two_a_irq; // [R13]
        src_vec[POS_MULTIFUNCTION_TIMER_TWO_B] = multifunction_timer_two_b_irq; // [R13]
        src_vec[POS_RTC] = rtc_irq;                             // [R14]
        src_vec[POS_DMA] = dma_irq;                             // [R19]
    end

    // The mask guards unassigned positions even if the table above is edited.
    assign masked_src = src_vec & CONNECTED_MASK; // [R15]

    // Two flops per user position, line and previous value; requests share clk, so no synchroniser is needed.
    generate
        for (genvar i = 0; i < NUM_USER; i++)
        begin : g_line
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    user_irq_r[i] <= 1'b0;                       // [R20]
                    user_irq_prev_r[i] <= 1'b0;
                end
                else
                begin
                    user_irq_r[i] <= masked_src[i];              // [R2] [R20]
                    user_irq_prev_r[i] <= user_irq_r[i];
                end
            end
            // A new assertion shows for one cycle, so short events are still visible.
            assign user_irq_rise[i] = user_irq_r[i] & ~user_irq_prev_r[i];
        end
    endgenerate

    assign user_irq = user_irq_r; // [R1]

    // Per-position priority levels, cleared to level zero by reset.
    pivm_prio_table #(
        .DEPTH(NUM_USER),
        .WIDTH(PRIO_BITS),
        .AW(POS_W)
    ) u_prio_table (
        .clk(clk),
        .nrst(nrst),
        .wr_en(prio_wr_en),                                     // [R16]
        .wr_addr(prio_wr_pos),
        .wr_data(prio_wr_level),
        .rd_addr(scan_addr_r),
        .rd_data(rd_level)
    );

    // Sweep sequencing: read every table entry once, then publish.
    always_comb
    begin
        case (scan_st_r)
            PIVM_SCAN_IDLE:
                scan_st_nxt = PIVM_SCAN_RUN;
            PIVM_SCAN_RUN:
                scan_st_nxt = (scan_addr_r == POS_W'(NUM_USER - 1)) ? PIVM_SCAN_PUBLISH : PIVM_SCAN_RUN;
            PIVM_SCAN_PUBLISH:
                scan_st_nxt = PIVM_SCAN_RUN;
            default:
                scan_st_nxt = PIVM_SCAN_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            scan_st_r <= PIVM_SCAN_IDLE;
        else
            scan_st_r <= scan_st_nxt;
    end

    // Read address walks through the positions while running.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            scan_addr_r <= '0;
        else if (scan_st_r == PIVM_SCAN_RUN)
            scan_addr_r <= scan_addr_r + POS_W'(1);
        else
            scan_addr_r <= '0;
    end

    // The table answers one cycle later, so the position travels alongside.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            data_vld_r <= 1'b0;
            data_pos_r <= '0;
        end
        else
        begin
            data_vld_r <= (scan_st_r == PIVM_SCAN_RUN);
            data_pos_r <= scan_addr_r;
        end
    end

    // Compare the arriving entry with the best so far.
    always_comb
    begin
        entry_crit = CRITICAL_MASK[data_pos_r];
        take = 1'b0;
        if (data_vld_r && user_irq_r[data_pos_r])
        begin
            if (!best_vld_r)
                take = 1'b1;
            else if (entry_crit && !best_crit_r)
                take = 1'b1;                                    // [R7]
            else if (entry_crit == best_crit_r && rd_level < best_level_r)
                take = 1'b1;
        end
        cand_vld = best_vld_r | take;
        cand_pos = take ? data_pos_r : best_pos_r;
        cand_level = take ? rd_level : best_level_r;
        cand_crit = take ? entry_crit : best_crit_r;
    end

    // Running best; cleared at the start of every sweep.
    always_ff @(posedge clk)
    begin
        if (!nrst || scan_st_r == PIVM_SCAN_PUBLISH)
        begin
            best_vld_r <= 1'b0;
            best_pos_r <= '0;
            best_level_r <= '0;
            best_crit_r <= 1'b0;
        end
        else
        begin
            best_vld_r <= cand_vld;
            best_pos_r <= cand_pos;
            best_level_r <= cand_level;
            best_crit_r <= cand_crit;
        end
    end

    // Publish once per sweep; drop the claim as soon as its line falls.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pend_valid_r <= 1'b0;
            pend_pos_r <= '0;
            pend_vector_addr_r <= USER_VEC_FIRST;
            pend_level_r <= '0;
            pend_critical_r <= 1'b0;
        end
        else if (scan_st_r == PIVM_SCAN_PUBLISH)
        begin
            pend_valid_r <= cand_vld && masked_src[cand_pos];
            pend_pos_r <= cand_pos;
            pend_vector_addr_r <= USER_VEC_FIRST + (32'(cand_pos) << 2); // [R1]
            pend_level_r <= cand_level;
            pend_critical_r <= cand_crit;
        end
        else if (!masked_src[pend_pos_r])
            pend_valid_r <= 1'b0;
    end

    assign pend_valid = pend_valid_r;
    assign pend_pos = pend_pos_r;
    assign pend_vector_addr = pend_vector_addr_r;
    assign pend_level = pend_level_r;
    assign pend_critical = pend_critical_r;

    // Core exception table: vector address, listed priority and whether it is fixed.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sys_exc_valid_r <= 1'b0;
            sys_exc_addr_r <= CORE_VEC_FIRST;
            sys_exc_prio_r <= '0;
            sys_exc_fixed_r <= 1'b0;
        end
        else
        begin
            sys_exc_addr_r <= CORE_VEC_FIRST + (32'(sys_exc_num) << 2);
            case (sys_exc_num)
                EXC_NUM_RESET:
                begin
                    sys_exc_valid_r <= 1'b1;
                    sys_exc_prio_r <= PRIO_RESET_EXC;            // [R17]
                    sys_exc_fixed_r <= 1'b1;
                end
                EXC_NUM_NMI:
                begin
                    sys_exc_valid_r <= 1'b1;
                    sys_exc_prio_r <= PRIO_NMI_EXC;              // [R17]
                    sys_exc_fixed_r <= 1'b1;
                end
                EXC_NUM_SEVERE_FAULT:
                begin
                    sys_exc_valid_r <= 1'b1;
                    sys_exc_prio_r <= PRIO_SEVERE_FAULT_EXC;     // [R17]
                    sys_exc_fixed_r <= 1'b1;
                end
                EXC_NUM_SUPERVISOR_CALL:
                begin
                    sys_exc_valid_r <= 1'b1;
                    sys_exc_prio_r <= PRIO_SUPERVISOR_CALL_EXC;  // [R18]
                    sys_exc_fixed_r <= 1'b0;
                end
                EXC_NUM_PENDING_SERVICE:
                begin
                    sys_exc_valid_r <= 1'b1;
                    sys_exc_prio_r <= PRIO_PENDING_SERVICE_EXC;  // [R18]
                    sys_exc_fixed_r <= 1'b0;
                end
                EXC_NUM_PERIODIC_TICK:
                begin
                    sys_exc_valid_r <= 1'b1;
                    sys_exc_prio_r <= PRIO_PERIODIC_TICK_EXC;    // [R18]
                    sys_exc_fixed_r <= 1'b0;
                end
                default:
                begin
                    sys_exc_valid_r <= 1'b0;
                    sys_exc_prio_r <= '0;
                    sys_exc_fixed_r <= 1'b0;
                end
            endcase
        end
    end

    assign sys_exc_valid = sys_exc_valid_r;
    assign sys_exc_addr = sys_exc_addr_r;
    assign sys_exc_prio = sys_exc_prio_r;
    assign sys_exc_fixed = sys_exc_fixed_r;

endmodule // pivm_irq_vector_map

// *** verif/pivm_irq_vector_map_monitor.sv ***
`timescale 1ns/1ps
module pivm_irq_vector_map_monitor #(
    parameter int PRIO_BITS = 2
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Peripheral requests.
    input wire logic gpio_irq,
    input wire logic flash_irq,
    input wire logic uart_irq,
    input wire logic spi_irq,
    input wire logic radio_irq,
    input wire logic watchdog_irq,
    input wire logic adc_irq,
    input wire logic i2c_two_irq,
    input wire logic i2c_one_irq,
    input wire logic multifunction_timer_one_a_irq,
    input wire logic multifunction_timer_one_b_irq,
    input wire logic multifunction_timer_two_a_irq,
    input wire logic multifunction_timer_two_b_irq,
    input wire logic rtc_irq,
    input wire logic dma_irq,
    // Lookup input and map outputs.
    input wire logic [3:0] sys_exc_num,
    input wire logic [pivm_pkg::NUM_USER-1:0] user_irq,
    input wire logic [pivm_pkg::NUM_USER-1:0] user_irq_rise,
    input wire logic pend_valid,
    input wire logic [pivm_pkg::POS_W-1:0] pend_pos,
    input wire logic [31:0] pend_vector_addr,
    input wire logic pend_critical,
    input wire logic sys_exc_valid,
    input wire logic [31:0] sys_exc_addr,
    input wire logic signed [3:0] sys_exc_prio,
    input wire logic sys_exc_fixed
);
    import pivm_pkg::*;

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Requests placed at their user positions, one cycle behind, for comparison with the lines.
    logic [31:0] want_r;
    always_ff @(posedge clk)
    begin
        want_r <= {8'h00, dma_irq, 1'b0, rtc_irq, multifunction_timer_two_b_irq, multifunction_timer_two_a_irq,
                   multifunction_timer_one_b_irq, multifunction_timer_one_a_irq, 1'b0, i2c_one_irq, i2c_two_irq,
                   adc_irq, 5'h00, watchdog_irq, radio_irq, spi_irq, uart_irq, 2'h0, flash_irq, gpio_irq};
    end

    a_map_low_group: assert property ($past(nrst) |-> user_irq[7:0] == want_r[7:0])
        else $error("low lines off");
    a_map_mid_group: assert property ($past(nrst) |-> user_irq[15:8] == want_r[15:8])
        else $error("middle lines off");
    a_map_high_group: assert property ($past(nrst) |-> user_irq[31:16] == want_r[31:16])
        else $error("high lines off");
    a_unmapped_quiet: assert property ((user_irq & 32'hFF41_1F0C) == 32'h0000_0000)
        else $error("sourceless line high");
    a_rise_pulse: assert property (user_irq_rise == (user_irq & ~$past(user_irq)))
        else $error("rise pulse wrong");
    a_vector_addr: assert property (pend_vector_addr == 32'h0000_0040 + {25'h0000000, pend_pos, 2'h0})
        else $error("pending vector wrong");
    a_pend_live: assert property (pend_valid |-> user_irq[pend_pos])
        else $error("pending without line");
    a_critical_flag: assert property (pend_valid |-> pend_critical == (pend_pos == 5'h06))
        else $error("critical flag wrong");
    a_critical_wins: assert property ($rose(user_irq[6]) |-> ##[1:67] (!user_irq[6] || (pend_valid && pend_pos == 5'h06)))
        else $error("radio not selected");
    a_exc_reset: assert property (sys_exc_num == 4'h1 |=> sys_exc_valid && sys_exc_fixed && sys_exc_prio == -4'sh3 &&
                                  sys_exc_addr == 32'h0000_0004)
        else $error("reset answer wrong");
    a_exc_fault: assert property (sys_exc_num == 4'h3 |=> sys_exc_fixed && sys_exc_prio == -4'sh1 &&
                                  sys_exc_addr == 32'h0000_000C)
        else $error("fault answer wrong");
    a_exc_settable: assert property (sys_exc_num == 4'hF |=> !sys_exc_fixed && sys_exc_prio == 4'sh6 &&
                                     sys_exc_addr == 32'h0000_003C)
        else $error("tick answer wrong");
endmodule // pivm_irq_vector_map_monitor

bind pivm_irq_vector_map pivm_irq_vector_map_monitor #(.PRIO_BITS(PRIO_BITS)) pivm_irq_vector_map_monitor_inst (.*);

// *** verif/pivm_core_model.sv ***
`timescale 1ns/1ps
module pivm_core_model #(
    parameter int PRIO_BITS = 2
)
(
    // Clock.
    input wire logic clk,
    // Pending interrupt seen by the core.
    input wire logic pend_valid,
    input wire logic [31:0] pend_vector_addr,
    // Priority programming and exception lookup towards the map.
    output logic prio_wr_en,
    output logic [pivm_pkg::POS_W-1:0] prio_wr_pos,
    output logic [PRIO_BITS-1:0] prio_wr_level,
    output logic [3:0] sys_exc_num
);
    import pivm_pkg::*;

    // Idle start on the reset exception.
    initial
    begin
        prio_wr_en = 1'b0;
        prio_wr_pos = 5'h00;
        prio_wr_level = '0;
        sys_exc_num = 4'h1;
    end

    // Writes one priority level as a single-cycle strobe.
    task automatic set_prio(input logic [4:0] pos, input logic [PRIO_BITS-1:0] lvl);
        @(posedge clk);
        prio_wr_en <= 1'b1;
        prio_wr_pos <= pos;
        prio_wr_level <= lvl;
        @(posedge clk);
        prio_wr_en <= 1'b0;
    endtask

    // Presents an exception number and returns once the answer has settled.
    task automatic look(input logic [3:0] num);
        @(posedge clk);
        sys_exc_num <= num;
        @(posedge clk);
        #1;
    endtask
endmodule // pivm_core_model

// *** verif/pivm_irq_vector_map_tb.sv ***
`timescale 1ns/1ps
module pivm_irq_vector_map_tb;
    import pivm_pkg::*;
    localparam int PB = 2;
    logic clk;
    logic nrst;
    logic [14:0] req;
    logic prio_wr_en;
    logic [4:0] prio_wr_pos;
    logic [PB-1:0] prio_wr_level;
    logic [3:0] sys_exc_num;
    logic [31:0] user_irq;
    logic [31:0] user_irq_rise;
    logic pend_valid;
    logic [4:0] pend_pos;
    logic [31:0] pend_vector_addr;
    logic [PB-1:0] pend_level;
    logic pend_critical;
    logic sys_exc_valid;
    logic [31:0] sys_exc_addr;
    logic signed [3:0] sys_exc_prio;
    logic sys_exc_fixed;
    int n_fail;
    int compares;
    logic [31:0] lfsr;
    logic [31:0] prev;
    logic [14:0] r;
    // User position of each request bit, in port order.
    int pos_tab[15] = '{0, 1, 4, 5, 6, 7, 13, 14, 15, 17, 18, 19, 20, 21, 23};

    pivm_irq_vector_map #(.PRIO_BITS(PB)) pivm_irq_vector_map_inst
    (
        .gpio_irq(req[0]), .flash_irq(req[1]), .uart_irq(req[2]), .spi_irq(req[3]), .radio_irq(req[4]),
        .watchdog_irq(req[5]), .adc_irq(req[6]), .i2c_two_irq(req[7]), .i2c_one_irq(req[8]),
        .multifunction_timer_one_a_irq(req[9]), .multifunction_timer_one_b_irq(req[10]),
        .multifunction_timer_two_a_irq(req[11]), .multifunction_timer_two_b_irq(req[12]),
        .rtc_irq(req[13]), .dma_irq(req[14]), .*
    );

    pivm_core_model #(.PRIO_BITS(PB)) pivm_core_model_inst (.*);

    // Clock at 200 MHz.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Next value of the stimulus shift register.
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // User lines expected for a request pattern.
    function automatic logic [31:0] exp_map(input logic [14:0] p);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 15; i++)
            m[pos_tab[i]] = p[i];
        return m;
    endfunction

    // Valid, fixed and priority expected for an exception number.
    function automatic logic [5:0] exp_exc(input logic [3:0] n);
        case (n)
            4'h1: return 6'h3D;
            4'h2: return 6'h3E;
            4'h3: return 6'h3F;
            4'hB: return 6'h23;
            4'hE: return 6'h25;
            4'hF: return 6'h26;
            default: return 6'h00;
        endcase
    endfunction

    // Compares one value and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t %s", $time, what);
        end
    endtask

    // Drives a request pattern at a clock edge.
    task automatic drive(input logic [14:0] p);
        @(posedge clk);
        req <= p;
    endtask

    // Lets n edges pass and steps past the last one.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Run limit.
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("mismatch %0t run limit reached", $time);
        complete_run();
    end

    // Main sequence.
    initial
    begin
        nrst = 1'b0;
        req = 15'h0000;
        n_fail = 0;
        compares = 0;
        lfsr = 32'h0001_298D;
        prev = 32'h0000_0000;
        settle(16);
        chk(user_irq, 32'h0000_0000, "lines during reset");
        chk({31'h0, pend_valid}, 32'h0000_0000, "pending during reset");
        chk(pend_vector_addr, 32'h0000_0040, "vector during reset");
        @(posedge clk);
        nrst <= 1'b1;
        for (int n = 0; n < 16; n++)
        begin
            pivm_core_model_inst.look(n[3:0]);
            chk({26'h0, sys_exc_valid, sys_exc_fixed, sys_exc_prio}, {26'h0, exp_exc(n[3:0])}, "exception");
            chk(sys_exc_addr, {26'h0, n[3:0], 2'h0}, "exception address");
        end
        for (int i = 0; i < 60; i++)
        begin
            lfsr = lfsr_next(lfsr);
            r = (i == 0) ? 15'h7FFF : (i == 1) ? 15'h0000 : lfsr[14:0];
            drive(r);
            settle(1);
            chk(user_irq, exp_map(r), "user lines");
            chk(user_irq_rise, exp_map(r) & ~prev, "rise pulses");
            prev = exp_map(r);
        end
        for (int i = 0; i < 15; i++)
        begin
            drive(15'h0001 << i);
            settle(70);
            chk({27'h0, pend_pos}, pos_tab[i], "lone source position");
            chk(pend_vector_addr, 32'h0000_0040 + 4 * pos_tab[i], "lone source vector");
            chk({31'h0, pend_critical}, {31'h0, i == 4}, "critical class");
        end
        drive(15'h002C);
        settle(70);
        chk({27'h0, pend_pos}, 32'h0000_0004, "equal levels tie");
        pivm_core_model_inst.set_prio(5'h04, 2'h1);
        pivm_core_model_inst.set_prio(5'h05, 2'h1);
        settle(70);
        chk({25'h0, pend_level, pend_pos}, 32'h0000_0007, "lower level wins");
        pivm_core_model_inst.set_prio(5'h06, 2'h3);
        drive(15'h003C);
        settle(70);
        chk({25'h0, pend_level, pend_pos}, 32'h0000_0066, "critical over levels");
        drive(15'h0000);
        settle(1);
        chk({31'h0, pend_valid}, 32'h0000_0000, "pending drops with line");
        @(posedge clk);
        nrst <= 1'b0;
        req <= 15'h002C;
        settle(2);
        chk(user_irq, 32'h0000_0000, "lines held in reset");
        @(posedge clk);
        nrst <= 1'b1;
        settle(70);
        chk({27'h0, pend_pos}, 32'h0000_0004, "levels back to zero");
        complete_run();
    end
endmodule // pivm_irq_vector_map_tb
